// ===== hdl/sram_host_pkg.sv
// package for the asynchronous byte memory host controller
// assumes a single 200 MHz clock domain
package sram_host_pkg;
    localparam int  addr_width      = 19;
    localparam int  data_width      = 8;
    localparam int  clk_period_ps   = 5000;
    // timing figures in picoseconds, cycles rounded up
    localparam int  index_to_valid_time_ps  = 15000;
    localparam int  select_to_valid_time_ps = 15000;
    localparam int  drive_to_valid_time_ps  = 15000;
    localparam int  read_cycle_time_ps      = 15000;
    localparam int  store_pulse_width_ps    = 15000;
    localparam int  store_to_float_time_ps  = 15000;
    localparam int  read_cycles  =
        (index_to_valid_time_ps + clk_period_ps - 1) / clk_period_ps + 1;
    localparam int  cycle_cycles =
        (read_cycle_time_ps + clk_period_ps - 1) / clk_period_ps;
    localparam int  store_cycles =
        (store_pulse_width_ps + clk_period_ps - 1) / clk_period_ps;
    localparam int  float_cycles =
        (store_to_float_time_ps + clk_period_ps - 1) / clk_period_ps;
    localparam int  count_width  = 4;
    localparam logic [count_width-1:0] count_zero = 4'h0;
    localparam logic [count_width-1:0] count_one  = 4'h1;

    typedef enum logic [2:0] {
        st_idle  = 3'b000,
        st_read  = 3'b001,
        st_float = 3'b011,
        st_store = 3'b010,
        st_done  = 3'b110
    } phase_e;

    typedef struct packed {
        logic                  chip_select_low_active;
        logic                  chip_select_high_active;
        logic                  store_strobe_n;
        logic                  drive_strobe_n;
        logic [addr_width-1:0] index;
        logic [data_width-1:0] data_out;
        logic                  data_oe;
    } pins_s;
endpackage : sram_host_pkg

// ===== hdl/cycle_timer.sv
// down counter that flags when a loaded interval has run out
// assumes the loader gives a count of at least one
`timescale 1ns/1ps
module cycle_timer
    import sram_host_pkg::*;
#(
    parameter int width = count_width
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // control
    input  wire logic             load,
    input  wire logic [width-1:0] value,
    // status
    output logic                  expired
);
    if (width < 1) begin : g_bad_width
        $error("cycle_timer needs a counter of at least one bit");
    end
    typedef struct packed {
        logic [width-1:0] count;
        logic             expired;
    } timer_s;
    timer_s state;
    timer_s next_state;

    always_comb begin
        next_state = state;
        if (load) begin
            next_state.count   = value;
            next_state.expired = 1'b0;
        end else if (state.count != '0) begin
            next_state.count   = state.count - 1'b1;
            next_state.expired = (state.count == 1);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign expired = state.expired;
endmodule : cycle_timer

// ===== hdl/sram_host.sv
// host controller driving an asynchronous 512K by 8 static memory
// assumes the memory pins are sampled and driven on clk; the bench
// resolves the data wire from data_oe and the memory's own enable
`timescale 1ns/1ps
module sram_host
    import sram_host_pkg::*;
#(
    parameter int aw = addr_width,
    parameter int dw = data_width
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // user request
    input  wire logic          req_valid,
    input  wire logic          req_write,
    input  wire logic [aw-1:0] req_index,
    input  wire logic [dw-1:0] req_data,
    output logic               req_ready,
    // user answer
    output logic               rsp_valid,
    output logic [dw-1:0]      rsp_data,
    // memory pins
    output logic               chip_select_low_active,
    output logic               chip_select_high_active,
    output logic               store_strobe_n,
    output logic               drive_strobe_n,
    output logic [aw-1:0]      index,
    output logic [dw-1:0]      data_out,
    output logic               data_oe,
    input  wire logic [dw-1:0] data_in
);
    // ********************************************************
    // elaboration checks
    // ********************************************************
    if (aw != addr_width || dw != data_width) begin : g_bad_width
        $error("sram_host widths must match the memory");
    end
    if (read_cycles >= 16 || store_cycles >= 16) begin : g_bad_count
        $error("sram_host timing counts exceed the timer");
    end
    if (float_cycles < 1 || float_cycles >= 16) begin : g_bad_float
        $error("sram_host float count exceeds the timer");
    end

    // waits in picoseconds as the timer will really count them
    localparam int read_wait_ps  = read_cycles * clk_period_ps;
    localparam int store_wait_ps = store_cycles * clk_period_ps;
    localparam int float_wait_ps = float_cycles * clk_period_ps;

    // the read wait has to cover the slowest access path
    if (read_wait_ps < index_to_valid_time_ps ||
        read_wait_ps < select_to_valid_time_ps ||
        read_wait_ps < drive_to_valid_time_ps) begin : g_short_read
        $error("sram_host read wait shorter than an access time");
    end
    // a pulse shorter than the write width may lose the byte
    if (store_wait_ps < store_pulse_width_ps) begin : g_short_store
        $error("sram_host store pulse shorter than its width");
    end
    // data driven before the memory floats would clash
    if (float_wait_ps < store_to_float_time_ps) begin : g_short_float
        $error("sram_host float wait shorter than the float time");
    end
    // one read holds the index for the read wait plus two cycles
    if (cycle_cycles > read_cycles + 2) begin : g_short_cycle
        $error("sram_host index changes faster than the cycle time");
    end

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        phase_e         phase;
        pins_s          pins;
        logic           ready;
        logic           rsp_valid;
        logic [dw-1:0]  rsp_data;
    } host_s;
    host_s state;
    host_s next_state;

    logic                   load;
    logic [count_width-1:0] load_value;
    logic                   expired;

    cycle_timer #(
        .width (count_width)
    ) u_timer (
        .clk     (clk),
        .resetn  (resetn),
        .load    (load),
        .value   (load_value),
        .expired (expired)
    );

    // ********************************************************
    // sequencing
    // ********************************************************
    always_comb begin
        next_state           = state;
        next_state.rsp_valid = 1'b0;
        load                 = 1'b0;
        load_value           = count_one;
        unique case (state.phase)
            st_idle: begin
                next_state.ready = 1'b1;
                if (state.ready && req_valid) begin
                    next_state.ready = 1'b0;
                    next_state.pins.index = req_index;
                    next_state.pins.chip_select_low_active  = 1'b0;
                    next_state.pins.chip_select_high_active = 1'b1;
                    load = 1'b1;
                    if (req_write) begin
                        // drive strobe high first so outputs float
                        next_state.pins.drive_strobe_n = 1'b1;
                        next_state.pins.store_strobe_n = 1'b0;
                        next_state.pins.data_out = req_data;
                        load_value = count_width'(float_cycles);
                        next_state.phase = st_float;
                    end else begin
                        // selects, drive and index all at once
                        next_state.pins.store_strobe_n = 1'b1;
                        next_state.pins.drive_strobe_n = 1'b0;
                        load_value = count_width'(read_cycles);
                        next_state.phase = st_read;
                    end
                end
            end
            st_read: begin
                // sample after the longest access time
                if (expired) begin
                    next_state.rsp_valid = 1'b1;
                    next_state.rsp_data  = data_in;
                    next_state.pins.drive_strobe_n = 1'b1;
                    next_state.phase = st_done;
                    load = 1'b1;
                    load_value = count_one;
                end
            end
            st_float: begin
                if (expired) begin
                    next_state.pins.data_oe = 1'b1;
                    load = 1'b1;
                    load_value = count_width'(store_cycles);
                    next_state.phase = st_store;
                end
            end
            st_store: begin
                // index and data held steady through the pulse
                if (expired) begin
                    // strobe rises while selects stay active
                    next_state.pins.store_strobe_n = 1'b1;
                    load = 1'b1;
                    load_value = count_one;
                    next_state.phase = st_done;
                end
            end
            st_done: begin
                // data held two cycles past the strobe, then standby
                if (expired) begin
                    next_state.pins.data_oe = 1'b0;
                    next_state.pins.chip_select_low_active  = 1'b1;
                    next_state.pins.chip_select_high_active = 1'b0;
                    next_state.phase = st_idle;
                end
            end
            default: begin
                next_state.phase = st_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= '{phase: st_idle,
                       pins: '{chip_select_low_active:  1'b1,
                               chip_select_high_active: 1'b0,
                               store_strobe_n:          1'b1,
                               drive_strobe_n:          1'b1,
                               index:                   '0,
                               data_out:                '0,
                               data_oe:                 1'b0},
                       ready: 1'b0,
                       rsp_valid: 1'b0,
                       rsp_data: '0};
        end else begin
            state <= next_state;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign req_ready               = state.ready;
    assign rsp_valid               = state.rsp_valid;
    assign rsp_data                = state.rsp_data;
    assign chip_select_low_active  = state.pins.chip_select_low_active;
    assign chip_select_high_active = state.pins.chip_select_high_active;
    assign store_strobe_n          = state.pins.store_strobe_n;
    assign drive_strobe_n          = state.pins.drive_strobe_n;
    assign index                   = state.pins.index;
    assign data_out                = state.pins.data_out;
    assign data_oe                 = state.pins.data_oe;
endmodule : sram_host

// ===== verification/sram_host_assertions.sv
// port checks on the byte memory host controller
// assumes a bind from the bench onto sram_host
`timescale 1ns/1ps
module sram_host_assertions
    import sram_host_pkg::*;
#(
    parameter int aw = addr_width
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // user side
    input  wire logic          req_valid,
    input  wire logic          req_write,
    input  wire logic          req_ready,
    input  wire logic          rsp_valid,
    // memory pins
    input  wire logic          chip_select_low_active,
    input  wire logic          chip_select_high_active,
    input  wire logic          store_strobe_n,
    input  wire logic          drive_strobe_n,
    input  wire logic [aw-1:0] index,
    input  wire logic          data_oe
);
    wire sel = !chip_select_low_active && chip_select_high_active;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_idle_standby: assert property (
        req_ready |-> !sel && store_strobe_n && drive_strobe_n && !data_oe)
        else $error("pins not idle while ready");
    a_read_answer: assert property (
        req_valid && req_ready && !req_write |-> ##6 rsp_valid)
        else $error("read answer late");
    a_read_hold: assert property (
        $fell(drive_strobe_n) |-> !drive_strobe_n [*5] ##1 rsp_valid)
        else $error("drive strobe too short");
    a_read_steady: assert property (
        !drive_strobe_n && !$past(drive_strobe_n)
        |-> $stable(index) && store_strobe_n && sel)
        else $error("read cycle disturbed");
    a_float_wait: assert property (
        $fell(store_strobe_n) |-> !data_oe [*3])
        else $error("data driven before float time");
    a_pulse_width: assert property (
        $fell(store_strobe_n) |-> !store_strobe_n [*3])
        else $error("store pulse too short");
    a_store_ends: assert property (
        $rose(store_strobe_n) |-> sel) else $error("write ended by select");
    a_index_write: assert property (
        !store_strobe_n && !$past(store_strobe_n) |-> $stable(index))
        else $error("index moved in write");
    a_oe_write: assert property (
        data_oe |-> sel && drive_strobe_n) else $error("bus clash");
endmodule : sram_host_assertions

// ===== verification/sram_model.sv
// behavioural byte memory answering on the host pins
// assumes the bench resolves the shared data wire
`timescale 1ns/1ps
module sram_model
    import sram_host_pkg::*;
(
    // selects and strobes
    input  wire logic                  chip_select_low_active,
    input  wire logic                  chip_select_high_active,
    input  wire logic                  store_strobe_n,
    input  wire logic                  drive_strobe_n,
    // index and data
    input  wire logic [addr_width-1:0] index,
    input  wire logic [data_width-1:0] data_wire,
    output logic      [data_width-1:0] q = 8'h00,
    output logic                       q_oe
);
    logic [data_width-1:0] mem [logic [addr_width-1:0]];
    wire sel = !chip_select_low_active && chip_select_high_active;
    wire wr  = sel && !store_strobe_n;
    assign q_oe = sel && store_strobe_n && !drive_strobe_n;
    always @(negedge wr) begin
        if (!$isunknown(index)) mem[index] = data_wire;
    end
    logic [data_width-1:0] stored;
    realtime               moved = 0.0;
    // data turns valid only once 15 ns pass with no change
    always @(index or sel or drive_strobe_n) moved = $realtime;
    always #1 begin
        stored = ~index[7:0];
        if (!$isunknown(index) && mem.exists(index)) stored = mem[index];
        q = ($realtime - moved < 15.0) ? ~stored : stored;
    end
endmodule : sram_model

// ===== verification/sram_host_bench.sv
// self-checking bench for the byte memory host controller
// assumes sram_model answers on the memory pins
`timescale 1ns/1ps
module sram_host_bench;
    import sram_host_pkg::*;
    typedef struct packed {
        logic                  w;
        logic [addr_width-1:0] i;
        logic [data_width-1:0] d;
    } row_s;
    logic clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [addr_width-1:0] req_index = 19'h00000, index;
    logic [data_width-1:0] req_data = 8'h00, rsp_data, data_out, q, got;
    logic req_ready, rsp_valid, data_oe, q_oe, store_strobe_n;
    logic chip_select_low_active, chip_select_high_active, drive_strobe_n;
    wire [data_width-1:0] data_in =
        q_oe ? q : data_oe ? data_out : ~index[7:0];
    int fails = 0, n_checks = 0, cyc = 0;
    row_s rows [11] = '{
        '{1'b1, 19'h00000, 8'hA5}, '{1'b1, 19'h00001, 8'h5A},
        '{1'b1, 19'h7FFFF, 8'h3C}, '{1'b0, 19'h00000, 8'hA5},
        '{1'b0, 19'h7FFFF, 8'h3C}, '{1'b1, 19'h00000, 8'h00},
        '{1'b0, 19'h00001, 8'h5A}, '{1'b0, 19'h00000, 8'h00},
        '{1'b1, 19'h40000, 8'hFF}, '{1'b0, 19'h40000, 8'hFF},
        '{1'b0, 19'h7FFFF, 8'h3C}};
    sram_host sram_host_i (.*);
    sram_model sram_model_i (.*, .data_wire(data_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic op(input logic w, input logic [addr_width-1:0] i,
                      input logic [data_width-1:0] d);
        int k;
        @(negedge clk);
        {req_valid, req_write, req_index, req_data} = {1'b1, w, i, d};
        for (k = 0; k < 40 && req_ready !== 1'b1; k++) @(negedge clk);
        check(req_ready, 1'b1);
        @(negedge clk);
        req_valid = 1'b0;
        for (k = 0; k < 40 && !w && rsp_valid !== 1'b1; k++) @(negedge clk);
        if (!w) check(rsp_valid, 1'b1);
        got = rsp_data;
    endtask : op
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        check(req_ready, 1'b0);
        check(chip_select_low_active, 1'b1);
        resetn = 1'b1;
        foreach (rows[k]) begin
            op(rows[k].w, rows[k].i, rows[k].d);
            if (!rows[k].w) check(got, rows[k].d);
        end
        @(negedge clk);
        {req_valid, req_write, req_index} = {1'b1, 1'b0, 19'h00001};
        repeat (3) @(negedge clk);
        resetn = 1'b0;
        req_valid = 1'b0;
        #1 check(chip_select_high_active, 1'b0);
        check(data_oe, 1'b0);
        @(negedge clk) resetn = 1'b1;
        op(1'b0, 19'h00001, 8'h00);
        check(got, 8'h5A);
        end_of_test();
    end
endmodule : sram_host_bench
bind sram_host sram_host_assertions #(.aw(aw)) sram_host_assertions_i (.*);
